/* vin_guard.sv */
// Function
// [RULE_01] Fault action byte at 56h, resets 80h.
// [RULE_02] Overvoltage fault pulls alert low, sets status.
// [RULE_03] Fault bits clear only by clear-faults command.
// [RULE_04] Mode 10: disable, then follow retry setting.
// [RULE_05] Mode 11: off while fault, resume below warn.
// [RULE_06] Retry 000: stay off until fault cleared.
// [RULE_07] Retry 111: retry until off, bias loss, fault.
// [RULE_08] Each retry waits for input below warn.
// [RULE_09] Retry interval is (delay+1) times 35 ms.
// [RULE_10] Overvoltage warn threshold at 57h, resets D360h.
// [RULE_11] Warn crossing sets status bits, notifies host.
// [RULE_12] Undervoltage warn at 58h, resets 1.10 strap.
// [RULE_13] Undervoltage fault clears only above warn threshold.
// [RULE_14] Threshold is mantissa times two to exponent.
// [RULE_15] Host programs thresholds between 0 and 19 V.
// [RULE_16] Overvoltage fault detected against limit at 55h.
// [RULE_17] Exponent bits 15:11, mantissa bits 10:0.
`timescale 1ns/10ps
module vin_guard #(
  parameter int RETRY_UNIT_CYCLES = vin_guard_pkg::RETRY_UNIT_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire vin_guard_pkg::cmd_req_t  cmd_req,
  input  wire logic                     write_protect,
  input  wire logic                     clear_faults,
  input  wire logic [15:0]              vin_measured,
  input  wire logic [15:0]              input_lockout_strap,
  input  wire vin_guard_pkg::power_ctl_t power_ctl,
  output vin_guard_pkg::cmd_rsp_t       cmd_rsp,
  output logic [15:0]                   status_word,
  output logic [7:0]                    status_input,
  output logic                          alert_line_n,
  output logic                          power_enable,
  output logic                          vin_uv_fault
);
  import vin_guard_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] ov_fault_limit_reg;
  logic [7:0]  over_fault_action_reg;
  logic [15:0] over_warn_threshold_reg;
  logic [15:0] under_warn_threshold_reg;
  logic        strap_taken_reg;
  out_state_t  state_reg;
  out_state_t  state_next;
  logic        retry_due_reg;

  wire wr_ok    = cmd_req.valid && cmd_req.write && !write_protect;
  wire wr_ovf   = wr_ok && (cmd_req.code == CMD_OV_FAULT_LIMIT);
  wire wr_act   = wr_ok && (cmd_req.code == CMD_OV_FAULT_ACTION);
  wire wr_ovw   = wr_ok && (cmd_req.code == CMD_OV_WARN_LIMIT);
  wire wr_uvw   = wr_ok && (cmd_req.code == CMD_UV_WARN_LIMIT);
  wire mapped   = (cmd_req.code == CMD_OV_FAULT_LIMIT) || (cmd_req.code == CMD_OV_FAULT_ACTION)
                || (cmd_req.code == CMD_OV_WARN_LIMIT) || (cmd_req.code == CMD_UV_WARN_LIMIT);

  // Writes land only when write protection is off; the engine above handles the byte count.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ov_fault_limit_reg       <= OV_FAULT_LIMIT_RST;         // see [RULE_16]
      over_fault_action_reg    <= OV_FAULT_ACTION_RST;        // see [RULE_01]
      over_warn_threshold_reg  <= OV_WARN_LIMIT_RST;          // see [RULE_10]
      under_warn_threshold_reg <= UV_WARN_LIMIT_RST;
      strap_taken_reg          <= 1'b0;
    end else begin
      if (wr_ovf) ov_fault_limit_reg <= cmd_req.wdata;
      if (wr_act) over_fault_action_reg <= cmd_req.wdata[7:0];  // see [RULE_01]
      if (wr_ovw) over_warn_threshold_reg <= cmd_req.wdata;     // see [RULE_10]
      strap_taken_reg <= 1'b1;
      // The strap is caught on the first edge after release, never under reset.
      if (!strap_taken_reg) begin
        under_warn_threshold_reg <= lin11_scale_110(input_lockout_strap);  // see [RULE_12]
      end else if (wr_uvw) begin
        under_warn_threshold_reg <= cmd_req.wdata;                         // see [RULE_12]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [15:0] rd_mux = (cmd_req.code == CMD_OV_FAULT_LIMIT)  ? ov_fault_limit_reg :
                       (cmd_req.code == CMD_OV_FAULT_ACTION) ? {8'h00, over_fault_action_reg} :
                       (cmd_req.code == CMD_OV_WARN_LIMIT)   ? over_warn_threshold_reg :
                       (cmd_req.code == CMD_UV_WARN_LIMIT)   ? under_warn_threshold_reg : 16'h0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_rsp <= '0;
    end else begin
      cmd_rsp.valid <= cmd_req.valid;
      cmd_rsp.error <= cmd_req.valid && (!mapped || (cmd_req.write && write_protect));
      cmd_rsp.rdata <= (cmd_req.valid && !cmd_req.write) ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Threshold compare
  // ----------------------------------------------------------------
  wire [23:0] vin_fix   = {8'h00, vin_measured};
  wire [23:0] ovf_fix   = lin11_to_fix(ov_fault_limit_reg);       // see [RULE_14] [RULE_17]
  wire [23:0] ovw_fix   = lin11_to_fix(over_warn_threshold_reg);  // see [RULE_14] [RULE_17]
  wire [23:0] uvw_fix   = lin11_to_fix(under_warn_threshold_reg); // see [RULE_14] [RULE_17]
  wire [23:0] uvf_fix   = lin11_to_fix(input_lockout_strap);
  wire        ov_fault  = vin_fix > ovf_fix;                      // see [RULE_16]
  wire        ov_warn   = vin_fix > ovw_fix;
  wire        below_ovw = vin_fix < ovw_fix;
  wire        uv_warn   = vin_fix < uvw_fix;
  wire        uv_trip   = vin_fix < uvf_fix;
  wire        above_uvw = vin_fix > uvw_fix;

  // ----------------------------------------------------------------
  // Status and alert
  // ----------------------------------------------------------------
  // Set wins over clear so a fault in the clearing cycle survives.
  wire [7:0] si_set = {ov_fault, ov_warn, uv_warn, vin_uv_fault, 4'h0};
  wire [7:0] si_next = (clear_faults ? 8'h00 : status_input) | si_set;  // see [RULE_03]
  wire       any_in  = |si_next;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_input <= 8'h00;
      status_word  <= 16'h0000;
      alert_line_n <= 1'b1;
      vin_uv_fault <= 1'b0;
    end else begin
      status_input <= si_next;                                            // see [RULE_02] [RULE_11]
      status_word  <= (16'(any_in) << SW_INPUT_BIT) | (16'(any_in) << SW_NOTA_BIT);  // see [RULE_11]
      alert_line_n <= !any_in;                                            // see [RULE_02] [RULE_11]
      if (uv_trip) begin
        vin_uv_fault <= 1'b1;
      end else if (above_uvw) begin
        vin_uv_fault <= 1'b0;                                             // see [RULE_13]
      end
    end
  end

  // ----------------------------------------------------------------
  // Output enable sequencing
  // ----------------------------------------------------------------
  wire [1:0] mode       = over_fault_action_reg[MODE_MSB:MODE_LSB];
  wire [2:0] retry      = over_fault_action_reg[RETRY_MSB:RETRY_LSB];
  wire [2:0] delay_code = over_fault_action_reg[DELAY_MSB:DELAY_LSB];
  wire       go_ok      = power_ctl.run_request && power_ctl.bias_ok && !power_ctl.other_fault;
  wire       retry_done;
  wire       start_wait = (state_next == ST_RETRY) && (state_reg != ST_RETRY);

  // Unused mode and retry codes fall back to the safe latched-off reaction.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_STOPPED: state_next = (go_ok && !ov_fault) ? ST_RUN : ST_STOPPED;
      ST_RUN: begin
        if (!go_ok) begin
          state_next = ST_STOPPED;
        end else if (ov_fault) begin
          if (mode == MODE_HOLD) begin
            state_next = ST_HOLD;                                         // see [RULE_05]
          end else if (mode == MODE_RETRY && retry == RETRY_LOOP) begin
            state_next = ST_RETRY;                                        // see [RULE_04] [RULE_07]
          end else begin
            state_next = ST_LATCHED;                                      // see [RULE_04] [RULE_06]
          end
        end
      end
      ST_LATCHED: state_next = clear_faults ? ST_STOPPED : ST_LATCHED;    // see [RULE_06]
      ST_HOLD: begin
        if (!go_ok) begin
          state_next = ST_STOPPED;
        end else if (!ov_fault && below_ovw) begin
          state_next = ST_RUN;                                            // see [RULE_05]
        end
      end
      ST_RETRY: begin
        if (!go_ok) begin
          state_next = ST_STOPPED;                                        // see [RULE_07]
        end else if (retry_due_reg && below_ovw) begin
          state_next = ST_RUN;                                            // see [RULE_08]
        end
      end
      default: state_next = ST_STOPPED;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= ST_STOPPED;
      retry_due_reg <= 1'b0;
      power_enable  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      retry_due_reg <= start_wait ? 1'b0 : (retry_due_reg | retry_done);  // see [RULE_09]
      power_enable  <= (state_next == ST_RUN);
    end
  end

  retry_timer #(
    .UNIT_CYCLES (RETRY_UNIT_CYCLES)
  ) u_retry_timer (
    .clk        (clk),
    .rstn       (rstn),
    .start      (start_wait),
    .delay_code (delay_code),
    .expired    (retry_done)
  );  // see [RULE_09]

endmodule : vin_guard

/* vin_guard_pkg.sv */
package vin_guard_pkg;

  // ----------------------------------------------------------------
  // Command codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_OV_FAULT_LIMIT   = 8'h55;
  localparam logic [7:0]  CMD_OV_FAULT_ACTION  = 8'h56;
  localparam logic [7:0]  CMD_OV_WARN_LIMIT    = 8'h57;
  localparam logic [7:0]  CMD_UV_WARN_LIMIT    = 8'h58;
  localparam logic [15:0] OV_FAULT_LIMIT_RST   = 16'hd380;
  localparam logic [7:0]  OV_FAULT_ACTION_RST  = 8'h80;
  localparam logic [15:0] OV_WARN_LIMIT_RST    = 16'hd360;
  localparam logic [15:0] UV_WARN_LIMIT_RST    = 16'h0000;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int          MODE_MSB    = 7;
  localparam int          MODE_LSB    = 6;
  localparam int          RETRY_MSB   = 5;
  localparam int          RETRY_LSB   = 3;
  localparam int          DELAY_MSB   = 2;
  localparam int          DELAY_LSB   = 0;
  localparam logic [1:0]  MODE_RETRY  = 2'h2;
  localparam logic [1:0]  MODE_HOLD   = 2'h3;
  localparam logic [2:0]  RETRY_NONE  = 3'h0;
  localparam logic [2:0]  RETRY_LOOP  = 3'h7;
  localparam int          EXP_MSB     = 15;
  localparam int          EXP_LSB     = 11;
  localparam int          MANT_MSB    = 10;
  localparam int          MANT_LSB    = 0;
  localparam int          FRAC_BITS   = 8;
  localparam logic [5:0]  FRAC_SHIFT  = 6'h08;

  // Status bit positions.
  localparam int          SW_INPUT_BIT = 13;
  localparam int          SW_NOTA_BIT  = 0;
  localparam int          SI_OV_FAULT  = 7;
  localparam int          SI_OV_WARN   = 6;
  localparam int          SI_UV_WARN   = 5;
  localparam int          SI_UV_FAULT  = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_PS    = 8000;
  localparam int          RETRY_UNIT_MS    = 35;
  localparam int          RETRY_UNIT_CYC   = RETRY_UNIT_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int          UNIT_CNT_W       = 23;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] rdata;
  } cmd_rsp_t;

  typedef struct packed {
    logic run_request;
    logic bias_ok;
    logic other_fault;
  } power_ctl_t;

  typedef enum logic [4:0] {
    ST_STOPPED = 5'h01,
    ST_RUN     = 5'h02,
    ST_LATCHED = 5'h04,
    ST_HOLD    = 5'h08,
    ST_RETRY   = 5'h10
  } out_state_t;

  // Linear-11 word to unsigned volts with FRAC_BITS fraction bits.
  function automatic logic [23:0] lin11_to_fix(input logic [15:0] w);
    logic signed [39:0] y;
    logic signed [5:0]  e;
    logic signed [39:0] v;
    y = 40'(signed'(w[MANT_MSB:MANT_LSB]));
    e = 6'(signed'(w[EXP_MSB:EXP_LSB])) + signed'(FRAC_SHIFT);
    if (e >= 0) begin
      v = y <<< e;
    end else begin
      v = y >>> (-e);
    end
    if (v < 0) begin
      lin11_to_fix = 24'h000000;
    end else if (v > 40'sh0000ffffff) begin
      lin11_to_fix = 24'hffffff;
    end else begin
      lin11_to_fix = v[23:0];
    end
  endfunction : lin11_to_fix

  // Linear-11 word scaled by 1.10, keeping the mantissa in range.
  function automatic logic [15:0] lin11_scale_110(input logic [15:0] w);
    logic signed [15:0] m;
    logic signed [4:0]  n;
    m = 16'(signed'(w[MANT_MSB:MANT_LSB]));
    n = w[EXP_MSB:EXP_LSB];
    m = 16'((m * 11) / 10);
    if (m > 16'sd1023 || m < -16'sd1024) begin
      m = m >>> 1;
      n = n + 5'sd1;
    end
    lin11_scale_110 = {n, m[10:0]};
  endfunction : lin11_scale_110

endpackage : vin_guard_pkg

/* retry_timer.sv */
`timescale 1ns/10ps
module retry_timer #(
  parameter int UNIT_CYCLES = vin_guard_pkg::RETRY_UNIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [2:0] delay_code,
  output logic            expired
);
  import vin_guard_pkg::*;

  logic [UNIT_CNT_W-1:0] cyc_reg;
  logic [3:0]            units_reg;
  logic                  busy_reg;
  wire                   unit_tick = busy_reg && (cyc_reg == UNIT_CNT_W'(UNIT_CYCLES - 1));
  wire                   last_unit = unit_tick && (units_reg == 4'h1);

  // The delay is latched at start so a rewrite mid-wait cannot stretch it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc_reg   <= '0;
      units_reg <= 4'h0;
      busy_reg  <= 1'b0;
      expired   <= 1'b0;
    end else begin
      expired <= last_unit;
      if (start) begin
        cyc_reg   <= '0;
        units_reg <= {1'b0, delay_code} + 4'h1;
        busy_reg  <= 1'b1;
      end else if (busy_reg) begin
        cyc_reg   <= unit_tick ? '0 : cyc_reg + UNIT_CNT_W'(1);
        units_reg <= unit_tick ? units_reg - 4'h1 : units_reg;
        busy_reg  <= !last_unit;
      end
    end
  end

endmodule : retry_timer

/* vin_guard_properties.sv */
`timescale 1ns/10ps
module vin_guard_properties
  import vin_guard_pkg::*;
#(
  parameter int RETRY_UNIT_CYCLES = RETRY_UNIT_CYC
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire cmd_req_t    cmd_req,
  input wire logic        write_protect,
  input wire logic        clear_faults,
  input wire logic [15:0] vin_measured,
  input wire logic [15:0] input_lockout_strap,
  input wire power_ctl_t  power_ctl,
  input wire cmd_rsp_t    cmd_rsp,
  input wire logic [15:0] status_word,
  input wire logic [7:0]  status_input,
  input wire logic        alert_line_n,
  input wire logic        power_enable,
  input wire logic        vin_uv_fault
);
  wire logic stop_req = !power_ctl.run_request || !power_ctl.bias_ok || power_ctl.other_fault;
  wire logic unmapped = (cmd_req.code < CMD_OV_FAULT_LIMIT) || (cmd_req.code > CMD_UV_WARN_LIMIT);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_rsp_timing; cmd_req.valid |=> cmd_rsp.valid; endproperty
  property p_no_stray; !cmd_req.valid |=> !cmd_rsp.valid; endproperty
  property p_protect; cmd_req.valid && cmd_req.write && write_protect |=> cmd_rsp.error; endproperty
  property p_unmapped; cmd_req.valid && unmapped |=> cmd_rsp.valid && cmd_rsp.error; endproperty
  property p_alert; alert_line_n == (status_input == 8'h00); endproperty
  property p_word; {status_word[13], status_word[0]} == {2{|status_input}}; endproperty
  property p_sticky; status_input[7] && !clear_faults |=> status_input[7]; endproperty
  property p_fault_off; $rose(status_input[7]) |-> ##[0:1] !power_enable; endproperty
  property p_stop; stop_req |-> ##[1:2] !power_enable; endproperty
  a_rsp_timing: assert property (p_rsp_timing) else $error("answer missing");
  a_no_stray: assert property (p_no_stray) else $error("stray answer");
  a_protect: assert property (p_protect) else $error("protected write taken");
  a_unmapped: assert property (p_unmapped) else $error("unmapped code taken");
  a_alert: assert property (p_alert) else $error("alert level wrong");
  a_word: assert property (p_word) else $error("summary bits wrong");
  a_sticky: assert property (p_sticky) else $error("fault bit lost");
  a_fault_off: assert property (p_fault_off) else $error("output kept on");
  a_stop: assert property (p_stop) else $error("output not stopped");
  c_restart: cover property ($rose(power_enable));
  c_fault: cover property ($rose(status_input[7]));
  c_refused: cover property (cmd_req.valid && write_protect);
endmodule : vin_guard_properties

bind vin_guard vin_guard_properties #(
  .RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)
) u_props (
  .clk(clk), .rstn(rstn), .cmd_req(cmd_req), .write_protect(write_protect),
  .clear_faults(clear_faults), .vin_measured(vin_measured),
  .input_lockout_strap(input_lockout_strap), .power_ctl(power_ctl), .cmd_rsp(cmd_rsp),
  .status_word(status_word), .status_input(status_input), .alert_line_n(alert_line_n),
  .power_enable(power_enable), .vin_uv_fault(vin_uv_fault)
);

/* vin_host_model.sv */
`timescale 1ns/10ps
module vin_host_model
  import vin_guard_pkg::*;
(
  input  wire logic     clk,
  output cmd_req_t      cmd_req,
  input  wire cmd_rsp_t cmd_rsp
);
  initial cmd_req = '0;
  // Thresholds go out as whole Linear-11 words of 0 V to 19 V.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output cmd_rsp_t rsp);
    cmd_req = '{1'b1, wr, code, data};
    // The answer is launched at the taking edge and stands for one cycle only,
    // so it is read just after that edge rather than racing the next one.
    @(posedge clk);
    #1;
    rsp = cmd_rsp;
    cmd_req.valid = 1'b0;
  endtask : xfer
endmodule : vin_host_model

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import vin_guard_pkg::*;
  localparam int          U     = 20;
  localparam logic [15:0] STRAP = 16'hd200;
  logic        clk           = 1'b0;
  logic        rstn          = 1'b0;
  logic        write_protect = 1'b0;
  logic        clear_faults  = 1'b0;
  logic [15:0] vin_measured  = 16'h0b00;
  power_ctl_t  power_ctl     = 3'b110;
  cmd_req_t    cmd_req;
  cmd_rsp_t    cmd_rsp;
  logic [15:0] status_word;
  logic [7:0]  status_input;
  logic        alert_line_n;
  logic        power_enable;
  logic        vin_uv_fault;
  int          n_errors      = 0;
  int          comparisons   = 0;
  always #4 clk = ~clk;
  vin_host_model host (.clk(clk), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp));
  vin_guard #(.RETRY_UNIT_CYCLES(U)) dut (
    .clk(clk), .rstn(rstn), .cmd_req(cmd_req), .write_protect(write_protect),
    .clear_faults(clear_faults), .vin_measured(vin_measured),
    .input_lockout_strap(STRAP), .power_ctl(power_ctl), .cmd_rsp(cmd_rsp),
    .status_word(status_word), .status_input(status_input), .alert_line_n(alert_line_n),
    .power_enable(power_enable), .vin_uv_fault(vin_uv_fault)
  );
  task automatic results();
    $display("compares %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic cmd(input logic wr, input logic [7:0] c, input logic [15:0] d,
                     input logic [15:0] e, input logic err);
    cmd_rsp_t r;
    host.xfer(wr, c, d, r);
    chk(16'({r.valid, r.error}), 16'({1'b1, err}));
    chk(r.rdata, e);
  endtask : cmd
  task automatic clr();
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(1);
  endtask : clr
  // Status summary and alert must always agree with the sticky input bits.
  task automatic stat(input logic [7:0] e);
    chk({8'h00, status_input}, {8'h00, e});
    chk(status_word, (e != 8'h00) ? 16'h2001 : 16'h0000);
    chk(16'(alert_line_n), 16'(e == 8'h00));
  endtask : stat
  task automatic wait_pe(input logic v, input int lim, output int n);
    n = 0;
    while (power_enable !== v && n < lim) begin
      cyc(1);
      n++;
    end
    chk(16'(power_enable), 16'(v));
    if (power_enable !== v) results();
  endtask : wait_pe
  initial begin
    int n;
    cyc(6);
    rstn = 1'b1;
    cyc(2);
    cmd(1'b0, CMD_OV_FAULT_ACTION, 16'h0000, 16'h0080, 1'b0);
    cmd(1'b0, CMD_OV_WARN_LIMIT, 16'h0000, 16'hd360, 1'b0);
    cmd(1'b0, CMD_UV_WARN_LIMIT, 16'h0000, {5'h1a, 11'(512 * 11 / 10)}, 1'b0);
    cmd(1'b0, CMD_OV_FAULT_LIMIT, 16'h0000, 16'hd380, 1'b0);
    cmd(1'b0, 8'h59, 16'h0000, 16'h0000, 1'b1);
    write_protect = 1'b1;
    cmd(1'b1, CMD_OV_WARN_LIMIT, 16'hd340, 16'h0000, 1'b1);
    write_protect = 1'b0;
    cmd(1'b0, CMD_OV_WARN_LIMIT, 16'h0000, 16'hd360, 1'b0);
    cmd(1'b1, CMD_OV_FAULT_ACTION, 16'h12c7, 16'h0000, 1'b0);
    cmd(1'b0, CMD_OV_FAULT_ACTION, 16'h0000, 16'h00c7, 1'b0);
    cmd(1'b1, CMD_OV_FAULT_ACTION, 16'h0080, 16'h0000, 1'b0);
    $display("test registers done");
    wait_pe(1'b1, 10, n);
    for (int i = 0; i < 3; i++) begin
      power_ctl = 3'b110 ^ (3'b100 >> i);
      wait_pe(1'b0, 3, n);
      power_ctl = 3'b110;
      wait_pe(1'b1, 4, n);
    end
    vin_measured = 16'h0e00;
    cyc(2);
    stat(8'h40);
    clr();
    stat(8'h40);
    chk(16'(power_enable), 16'h0001);
    vin_measured = 16'h0e10;
    cyc(2);
    stat(8'hc0);
    vin_measured = 16'h0b00;
    cyc(40);
    chk(16'(power_enable), 16'h0000);
    stat(8'hc0);
    clr();
    stat(8'h00);
    wait_pe(1'b1, 4, n);
    $display("test latched fault done");
    cmd(1'b1, CMD_OV_FAULT_ACTION, 16'h00c0, 16'h0000, 1'b0);
    vin_measured = 16'h0e10;
    wait_pe(1'b0, 4, n);
    vin_measured = 16'h0d90;
    cyc(30);
    chk(16'(power_enable), 16'h0000);
    vin_measured = 16'h0b00;
    wait_pe(1'b1, 4, n);
    $display("test hold mode done");
    for (int d = 0; d < 8; d++) begin
      cmd(1'b1, CMD_OV_FAULT_ACTION, 16'(8'hb8 + d), 16'h0000, 1'b0);
      vin_measured = 16'h0e10;
      wait_pe(1'b0, 4, n);
      vin_measured = 16'h0b00;
      wait_pe(1'b1, (d + 1) * U + 8, n);
      chk(16'(n >= (d + 1) * U - 2 && n <= (d + 1) * U + 4), 16'h0001);
      vin_measured = 16'h0e10;
      wait_pe(1'b0, 4, n);
      vin_measured = 16'h0d90;
      cyc((d + 1) * U + 8);
      chk(16'(power_enable), 16'h0000);
      vin_measured = 16'h0b00;
      wait_pe(1'b1, 4, n);
    end
    $display("test retry done");
    clr();
    vin_measured = 16'h0700;
    cyc(2);
    chk(16'(vin_uv_fault), 16'h0001);
    stat(8'h30);
    vin_measured = 16'h08cc;
    cyc(2);
    chk(16'(vin_uv_fault), 16'h0001);
    vin_measured = 16'h08cd;
    cyc(2);
    chk(16'(vin_uv_fault), 16'h0000);
    $display("test undervoltage done");
    results();
  end
endmodule : tb_top
